// ---- rtl/crsf_pkg.sv ----
// How it works
// (RULE1) Responses go out serially on the command line, leftmost bit first.
// (RULE2) Every response opens with start bit zero and direction bit zero.
// (RULE3) Every response codeword closes with an end bit of one.
// (RULE4) Only R1 and R1b carry CRC7; R2 sends register bits 7:1 there, R3 fixed check bits.
// (RULE5) R1 is 48 bits: index at 45:40, status at 39:8, CRC7 at 7:1.
// (RULE6) R1b sends R1 and may then hold DAT0 busy low.
// (RULE7) R2 is 136 bits: ones at 133:128, register bits 127:1, end bit.
// (RULE8) R2 carries identification for CMD2 and CMD10, card data for CMD9.
// (RULE9) R3 is 48 bits: ones at 45:40, OCR at 39:8, ones at 7:1.
// (RULE10) In R3, restricted voltage windows and card busy are sent low.
// (RULE11) R4 and R5 are never generated.
// (RULE12) A class C error bit clears once the response reporting it is sent.
// (RULE13) Status bits only inform and follow the current card condition.
// (RULE14) Validation errors go in the own response; command is skipped. R2 and R3 leave them in status for a later R1.
// (RULE15) Execution errors abort the operation, shown in the next response.
// (RULE16) Ended operations report validation errors to stop or status.
// (RULE17) Class A tracks state, B clears a valid command later, C on read.
// (RULE18) Bit 31 flags an address beyond range or transfer past capacity.
// (RULE19) Bit 30 flags a misaligned first block or later misaligned block.
// (RULE20) CRC7 uses x^7 + x^3 + 1 with the register starting at zero.
package crsf_pkg;

  localparam int unsigned CRSF_FRAME_W   = 136;
  localparam logic [7:0]  CRSF_R1_PAY    = 8'h28;
  localparam logic [7:0]  CRSF_R2_PAY    = 8'h87;
  localparam logic [7:0]  CRSF_R3_PAY    = 8'h2f;
  localparam logic [7:0]  CRSF_CRC_LEN   = 8'h07;
  localparam logic [7:0]  CRSF_R1_LEN    = 8'h30;
  localparam logic [7:0]  CRSF_R2_LEN    = 8'h88;
  localparam logic [5:0]  CRSF_CHECK6    = 6'h3f;
  localparam logic [6:0]  CRSF_CHECK7    = 7'h7f;
  localparam logic [6:0]  CRSF_CRC_INIT  = 7'h00;
  localparam logic [5:0]  CRSF_IDX_CSD   = 6'h09;
  localparam int unsigned CRSF_RANGE_BIT = 31;
  localparam int unsigned CRSF_ALIGN_BIT = 30;
  localparam logic [31:0] CRSF_ERR_C_MASK = 32'hfd38_0000;
  localparam logic [31:0] CRSF_ERR_B_MASK = 32'h00c0_0000;
  localparam logic [31:0] CRSF_STAT_A_MASK = 32'h0200_0000;
  localparam logic [31:0] CRSF_ERR_MASK  = CRSF_ERR_C_MASK | CRSF_ERR_B_MASK;
  localparam logic [31:0] CRSF_STATUS_RST = 32'h0000_0000;

  // Only four formats exist; no code is spent on R4 or R5.
  typedef enum logic [1:0] {
    CRSF_R1  = 2'h0,
    CRSF_R1B = 2'h1,
    CRSF_R2  = 2'h2,
    CRSF_R3  = 2'h3
  } crsf_rtype_t;

  typedef enum logic [2:0] {
    CRSF_IDLE = 3'h0,
    CRSF_SEND = 3'h1,
    CRSF_CRC  = 3'h2,
    CRSF_END  = 3'h3,
    CRSF_BUSY = 3'h4
  } crsf_fsm_t;

  typedef struct packed {
    crsf_rtype_t rtype;
    logic [5:0]  index;
    logic        busy;
  } crsf_req_t;

  typedef struct packed {
    crsf_fsm_t                 fsm;
    logic [CRSF_FRAME_W-1:0]   shreg;
    logic [7:0]                cnt;
    logic [6:0]                crc;
    logic                      is_r1;
    logic                      want_busy;
    logic [31:0]               status;
    logic [31:0]               snap;
    logic [31:0]               bpend;
    logic                      cmd_o;
    logic                      cmd_oe;
    logic                      dat0_o;
    logic                      dat0_oe;
    logic                      cmd_skip;
    logic                      exec_abort;
  } crsf_state_t;

  localparam crsf_state_t CRSF_STATE_RST = '{
    fsm: CRSF_IDLE, shreg: '0, cnt: 8'h00, crc: CRSF_CRC_INIT,
    is_r1: 1'b0, want_busy: 1'b0, status: CRSF_STATUS_RST,
    snap: CRSF_STATUS_RST, bpend: CRSF_STATUS_RST, cmd_o: 1'b1,
    cmd_oe: 1'b0, dat0_o: 1'b1, dat0_oe: 1'b0, cmd_skip: 1'b0,
    exec_abort: 1'b0};

endpackage

// ---- rtl/crsf_framer.sv ----
`timescale 1ns/1ps
module crsf_framer
  import crsf_pkg::*;
(
  input  wire logic         clk,           // Bus clock, one bit per rising edge.
  input  wire logic         rst_n,         // Synchronous reset, active low.
  input  wire crsf_req_t    req,           // Response type, index, busy.
  input  wire logic         req_valid,     // Response request present.
  output logic              req_ready,     // Framer idle, request taken.
  input  wire logic [127:0] cid_reg,       // Identification register.
  input  wire logic [127:0] csd_reg,       // Card-specific data register.
  input  wire logic [30:0]  ocr_volt,      // OCR low bits, low = restricted.
  input  wire logic         power_up_done, // High once the card is ready.
  input  wire logic [31:0]  stat_level,    // Current level of status bits.
  input  wire logic [31:0]  err_resp_set,  // Validation errors, this command.
  input  wire logic [31:0]  err_exec_set,  // Execution errors, pulse.
  input  wire logic         addr_oor_resp, // Address argument out of range.
  input  wire logic         addr_oor_exec, // Transfer ran past capacity.
  input  wire logic         misalign_resp, // First block misaligned.
  input  wire logic         misalign_exec, // Later block misaligned.
  input  wire logic         cmd_valid,     // Valid command received, pulse.
  input  wire logic         busy_done,     // Busy period may end.
  output logic              cmd_o,         // Command line output level.
  output logic              cmd_oe,        // Command line drive enable.
  output logic              dat0_o,        // DAT0 output level.
  output logic              dat0_oe,       // DAT0 drive enable.
  output logic              cmd_skip,      // Command must not execute.
  output logic              exec_abort,    // Running operation must stop.
  output logic [31:0]       status_word    // Card status word.
);

  crsf_state_t st_r;
  crsf_state_t st_nxt;

  logic                    accept;
  logic [31:0]             resp_all;
  logic [31:0]             exec_all;
  logic [31:0]             snap_q;
  logic                    resp_any;
  logic [CRSF_FRAME_W-1:0] frame;
  logic [7:0]              pay_len;
  logic [127:0]            r2_reg;
  logic [31:0]             ocr_word;

  // Serial CRC7 step, generator x^7 + x^3 + 1.
  function automatic logic [6:0] crsf_crc_step(input logic [6:0] c,
                                               input logic       b);
    logic fb;
    fb = b ^ c[6];
    return {c[5:3], c[2] ^ fb, c[1:0], fb}; // RULE20
  endfunction

  assign accept   = req_valid && req_ready;
  assign req_ready = (st_r.fsm == CRSF_IDLE);
  assign snap_q   = st_r.snap;
  assign resp_any = |resp_all;

  // The two address faults may come from either detection phase.
  always_comb begin
    resp_all = err_resp_set & CRSF_ERR_MASK;
    exec_all = err_exec_set & CRSF_ERR_MASK;
    resp_all[CRSF_RANGE_BIT] |= addr_oor_resp; // RULE18
    exec_all[CRSF_RANGE_BIT] |= addr_oor_exec; // RULE18
    resp_all[CRSF_ALIGN_BIT] |= misalign_resp; // RULE19
    exec_all[CRSF_ALIGN_BIT] |= misalign_exec; // RULE19
  end

  always_comb begin
    r2_reg = (req.index == CRSF_IDX_CSD) ? csd_reg : cid_reg; // RULE8
    ocr_word = {power_up_done, ocr_volt}; // RULE10
  end

  always_comb begin
    crsf_state_t n;
    logic [31:0] s;
    n = st_r;
    s = st_r.status;
    n.cmd_skip = 1'b0;
    n.exec_abort = 1'b0;
    frame = '0;
    pay_len = CRSF_R1_PAY;

    // A valid command clears class B bits reported one response earlier.
    if (cmd_valid) begin
      s = s & ~st_r.bpend; // RULE17
      n.bpend = '0;
    end
    // Class A bits follow the present condition every cycle.
    s = (s & CRSF_ERR_MASK) | (stat_level & CRSF_STAT_A_MASK); // RULE13

    unique case (req.rtype) // RULE11
      CRSF_R1, CRSF_R1B: begin
        frame[135:96] = {2'b00, req.index, 32'h0000_0000}; // RULE5
        pay_len = CRSF_R1_PAY;
      end
      CRSF_R2: begin
        frame[135:1] = {2'b00, CRSF_CHECK6, r2_reg[127:1]}; // RULE7
        pay_len = CRSF_R2_PAY;
      end
      CRSF_R3: begin
        frame[135:89] = {2'b00, CRSF_CHECK6, ocr_word, CRSF_CHECK7}; // RULE9
        pay_len = CRSF_R3_PAY;
      end
    endcase

    unique case (st_r.fsm)
      CRSF_IDLE: begin
        n.cmd_oe = 1'b0;
        n.cmd_o = 1'b1;
        if (accept) begin
          // Validation errors land in this command's own response when it is an R1 or R1b.
          s = s | resp_all; // RULE14 RULE16
          if (req.rtype == CRSF_R1 || req.rtype == CRSF_R1B) begin
            frame[127:96] = s; // RULE5
          end
          n.snap = s;
          n.cmd_skip = resp_any; // RULE14
          n.is_r1 = (req.rtype == CRSF_R1) || (req.rtype == CRSF_R1B); // RULE4
          n.want_busy = (req.rtype == CRSF_R1B) && req.busy; // RULE6
          n.cmd_o = frame[CRSF_FRAME_W-1]; // RULE1 RULE2
          n.cmd_oe = 1'b1;
          n.shreg = frame << 1;
          n.crc = crsf_crc_step(CRSF_CRC_INIT, frame[CRSF_FRAME_W-1]); // RULE20
          n.cnt = pay_len - 8'h01;
          n.fsm = CRSF_SEND;
        end
      end
      CRSF_SEND: begin
        if (st_r.cnt != 8'h00) begin
          n.cmd_o = st_r.shreg[CRSF_FRAME_W-1]; // RULE1
          n.shreg = st_r.shreg << 1;
          n.crc = crsf_crc_step(st_r.crc, st_r.shreg[CRSF_FRAME_W-1]);
          n.cnt = st_r.cnt - 8'h01;
        end else if (st_r.is_r1) begin
          n.cmd_o = st_r.crc[6]; // RULE4
          n.crc = {st_r.crc[5:0], 1'b0};
          n.cnt = CRSF_CRC_LEN - 8'h01;
          n.fsm = CRSF_CRC;
        end else begin
          n.cmd_o = 1'b1; // RULE3
          n.fsm = CRSF_END;
        end
      end
      CRSF_CRC: begin
        if (st_r.cnt != 8'h00) begin
          n.cmd_o = st_r.crc[6]; // RULE4
          n.crc = {st_r.crc[5:0], 1'b0};
          n.cnt = st_r.cnt - 8'h01;
        end else begin
          n.cmd_o = 1'b1; // RULE3
          n.fsm = CRSF_END;
        end
      end
      CRSF_END: begin
        // The end bit is on the line now; the frame is complete after it.
        n.cmd_oe = 1'b0;
        n.cmd_o = 1'b1;
        // Only R1 and R1b carry status, so only they retire reported errors.
        if (st_r.is_r1) begin
          s = s & ~(st_r.snap & CRSF_ERR_C_MASK); // RULE12 RULE17
          n.bpend = n.bpend | (st_r.snap & CRSF_ERR_B_MASK); // RULE17
        end
        if (st_r.want_busy) begin
          n.dat0_oe = 1'b1; // RULE6
          n.dat0_o = 1'b0;
          n.fsm = CRSF_BUSY;
        end else begin
          n.fsm = CRSF_IDLE;
        end
      end
      CRSF_BUSY: begin
        if (busy_done) begin
          n.dat0_oe = 1'b0;
          n.dat0_o = 1'b1;
          n.want_busy = 1'b0;
          n.fsm = CRSF_IDLE;
        end
      end
      default: begin
        n = CRSF_STATE_RST;
      end
    endcase

    // Execution errors stick until a later response carries them out.
    if (|exec_all) begin
      n.exec_abort = 1'b1; // RULE15
    end
    s = s | exec_all; // RULE15
    n.status = s;
    st_nxt = n;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= CRSF_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmd_o       = st_r.cmd_o;
  assign cmd_oe      = st_r.cmd_oe;
  assign dat0_o      = st_r.dat0_o;
  assign dat0_oe     = st_r.dat0_oe;
  assign cmd_skip    = st_r.cmd_skip;
  assign exec_abort  = st_r.exec_abort;
  assign status_word = st_r.status;

  // Helper state watched only by the checks below.
  logic [7:0] len_q;
  logic [5:0] idx_q;
  logic       pud_q;
  logic [6:0] crc_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_q <= 8'h00;
      idx_q <= 6'h00;
      pud_q <= 1'b0;
      crc_q <= CRSF_CRC_INIT;
    end else begin
      len_q <= cmd_oe ? len_q + 8'h01 : 8'h00;
      if (accept) begin
        idx_q <= req.index;
        pud_q <= power_up_done;
      end
      // Shadow CRC rebuilt from the line itself, then shifted out alongside.
      if (!cmd_oe) begin
        crc_q <= CRSF_CRC_INIT;
      end else if (len_q < CRSF_R1_PAY) begin
        crc_q <= crsf_crc_step(crc_q, cmd_o);
      end else begin
        crc_q <= {crc_q[5:0], 1'b0};
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_accept;
    accept;
  endsequence

  sequence seq_start_bits;
    (cmd_oe && !cmd_o) ##1 (cmd_oe && !cmd_o);
  endsequence

  sequence seq_check6;
    (cmd_oe && cmd_o) [*6];
  endsequence

  a_start_dir_bits: assert property ( // RULE2
    seq_accept |=> seq_start_bits)
    else $error("response does not open with two zero bits");

  a_frame_length: assert property ( // RULE5
    $fell(cmd_oe) |-> (len_q == CRSF_R1_LEN || len_q == CRSF_R2_LEN))
    else $error("response length is neither 48 nor 136 bits");

  a_end_bit_one: assert property ( // RULE3
    $fell(cmd_oe) |-> $past(cmd_o))
    else $error("response does not end with a one bit");

  a_r1_index_msb: assert property ( // RULE1
    (accept && req.rtype == CRSF_R1) |-> ##3 (cmd_o == idx_q[5])
      ##1 (cmd_o == idx_q[4]))
    else $error("command index not sent msb first at bit 45");

  a_r2_check_bits: assert property ( // RULE7
    (accept && req.rtype == CRSF_R2) |-> ##3 seq_check6)
    else $error("R2 check bits 133:128 are not all ones");

  a_r3_check_bits: assert property ( // RULE9
    (accept && req.rtype == CRSF_R3) |-> ##3 seq_check6 ##33 cmd_o [*8])
    else $error("R3 fixed check bits or end bit missing");

  a_busy_hold: assert property ( // RULE6
    (st_r.fsm == CRSF_BUSY && !busy_done) |=> (dat0_oe && !dat0_o))
    else $error("DAT0 busy released before busy_done");

  a_err_cleared: assert property ( // RULE12
    (st_r.fsm == CRSF_END && st_r.is_r1) |=>
      ((status_word & $past(snap_q) & CRSF_ERR_C_MASK & ~$past(exec_all))
       == 32'h0000_0000))
    else $error("reported error bit not cleared after response");

  a_skip_cause: assert property ( // RULE14
    cmd_skip |-> ($past(accept) && $past(resp_any)))
    else $error("command skipped without validation error");

  a_skip_on_err: assert property ( // RULE14
    (accept && resp_any) |=> cmd_skip)
    else $error("validation error did not skip the command");

  a_exec_abort: assert property ( // RULE15
    (|exec_all) |=> (exec_abort && ((status_word & $past(exec_all))
                                    == $past(exec_all))))
    else $error("execution error did not abort and stick");

  a_addr_range: assert property ( // RULE18
    addr_oor_exec |=> status_word[CRSF_RANGE_BIT])
    else $error("address range fault not raised");

  a_blk_align: assert property ( // RULE19
    misalign_exec |=> status_word[CRSF_ALIGN_BIT])
    else $error("block alignment fault not raised");

  a_r1_crc_bits: assert property ( // RULE4 RULE20
    (cmd_oe && st_r.is_r1 && len_q >= CRSF_R1_PAY &&
     len_q < CRSF_R1_PAY + CRSF_CRC_LEN) |-> (cmd_o == crc_q[6]))
    else $error("R1 check field differs from the sent bits");

  a_r3_busy_bit: assert property ( // RULE10
    (accept && req.rtype == CRSF_R3) |-> ##9 (cmd_o == pud_q))
    else $error("R3 card busy bit not sent at bit 39");

  a_idle_line_free: assert property ( // RULE1
    (st_r.fsm == CRSF_IDLE) |-> !cmd_oe)
    else $error("command line driven while idle");

  a_ready_refused: assert property ( // RULE1
    accept |=> !req_ready)
    else $error("request taken while a response is running");

  a_busy_release: assert property ( // RULE6
    (st_r.fsm == CRSF_BUSY && busy_done) |=>
      (!dat0_oe && dat0_o && req_ready))
    else $error("DAT0 busy not released after busy_done");

  a_class_b_clear: assert property ( // RULE17
    (cmd_valid && !accept) |=>
      ((status_word & $past(st_r.bpend) & ~$past(exec_all))
       == 32'h0000_0000))
    else $error("pending class B bit survived a valid command");

  a_class_a_follow: assert property ( // RULE13
    1'b1 |=> ((status_word & CRSF_STAT_A_MASK) ==
              ($past(stat_level) & CRSF_STAT_A_MASK)))
    else $error("class A status bit does not follow its level");

endmodule

// ---- tb/crsf_host_model.sv ----
`timescale 1ns/1ps
module crsf_host_model (
  input  wire logic         clk,     // Bus clock.
  input  wire logic         rst_n,   // Synchronous reset, active low.
  input  wire logic         cmd_o,   // Card command line level.
  input  wire logic         cmd_oe,  // Card drives command line.
  input  wire logic         dat0_o,  // Card DAT0 level.
  input  wire logic         dat0_oe, // Card drives DAT0.
  output logic              dat0,    // DAT0 wire as the host sees it.
  output logic [135:0]      frame,   // Last codeword, last bit in lsb.
  output logic [7:0]        nbits,   // Bit count of last codeword.
  output logic              done     // Codeword complete, pulse.
);
  logic cmd;
  logic oe_d;
  // Both lines carry pull-ups, so a released line reads high.
  assign cmd  = cmd_oe ? cmd_o : 1'b1;
  assign dat0 = dat0_oe ? dat0_o : 1'b1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_d  <= 1'b0;
      done  <= 1'b0;
      frame <= '0;
      nbits <= 8'h00;
    end else begin
      oe_d <= cmd_oe;
      done <= oe_d & ~cmd_oe;
      if (cmd_oe && !oe_d) begin
        frame <= {135'h0, cmd};
        nbits <= 8'h01;
      end else if (cmd_oe) begin
        frame <= {frame[134:0], cmd};
        nbits <= nbits + 8'h01;
      end
    end
  end
endmodule

// ---- tb/test_card_response_status_framer.sv ----
`timescale 1ns/1ps
module test_card_response_status_framer
  import crsf_pkg::*;
;
  logic clk, rst_n, req_valid, req_ready, power_up_done, busy_done;
  logic addr_oor_resp, addr_oor_exec, misalign_resp, misalign_exec;
  logic cmd_valid, cmd_o, cmd_oe, dat0_o, dat0_oe, cmd_skip, exec_abort;
  logic [127:0] cid_reg, csd_reg, rg;
  logic [30:0]  ocr_volt;
  logic [31:0]  stat_level, err_resp_set, err_exec_set, status_word;
  logic [135:0] h_frame;
  logic [7:0]   h_n;
  logic         h_dat0, h_done;
  crsf_req_t    req;
  int           n_fail, n_checks;

  crsf_framer dut (.clk, .rst_n, .req, .req_valid, .req_ready, .cid_reg,
    .csd_reg, .ocr_volt, .power_up_done, .stat_level, .err_resp_set,
    .err_exec_set, .addr_oor_resp, .addr_oor_exec, .misalign_resp,
    .misalign_exec, .cmd_valid, .busy_done, .cmd_o, .cmd_oe, .dat0_o,
    .dat0_oe, .cmd_skip, .exec_abort, .status_word);
  crsf_host_model host (.clk, .rst_n, .cmd_o, .cmd_oe, .dat0_o, .dat0_oe,
    .dat0(h_dat0), .frame(h_frame), .nbits(h_n), .done(h_done));

  always #2 clk = ~clk;

  task automatic chk(input logic [135:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic give_up(input string m);
    n_fail++;
    $display("MISMATCH t=%0t wait for %s ran out", $time, m);
    test_done();
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Check field of an R1 codeword, register starting at zero.
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ ({7{fb}} & 7'h09);
    end
    return c;
  endfunction

  function automatic logic [47:0] r1(input logic [5:0] i, logic [31:0] s);
    return {2'b00, i, s, crc7({2'b00, i, s}), 1'b1};
  endfunction

  task automatic send(input crsf_rtype_t t, logic [5:0] i, logic b);
    int k;
    k = 0;
    req = '{rtype: t, index: i, busy: b};
    req_valid = 1'b1;
    while (!req_ready && k < 300) begin
      step(1);
      k++;
    end
    if (k >= 300) give_up("ready");
    step(1);
    req_valid = 1'b0;
    {err_resp_set, addr_oor_resp, misalign_resp} = '0;
  endtask

  task automatic wait_frame();
    int k;
    k = 0;
    while (!h_done && k < 400) begin
      step(1);
      k++;
    end
    if (k >= 400) give_up("frame");
  endtask

  task automatic t_r1();
    stat_level = 32'h0200_0000;
    err_resp_set = 32'h0040_0001;
    addr_oor_resp = 1'b1;
    step(1);
    send(CRSF_R1, 6'h11, 1'b0);
    chk(cmd_skip, 1'b1, "skip");
    wait_frame();
    chk(h_n, 8'h30, "r1 length");
    chk(h_frame[47:0], r1(6'h11, 32'h8240_0000),
        "r1");
    chk(status_word, 32'h0240_0000, "c cleared");
    cmd_valid = 1'b1;
    step(1);
    cmd_valid = 1'b0;
    step(1);
    chk(status_word, 32'h0200_0000, "b cleared");
    stat_level = 32'h0;
    step(2);
    chk(status_word, 32'h0, "a follows");
    $display("test r1 done");
  endtask

  task automatic t_r2();
    logic [5:0] ix [3] = '{6'h02, 6'h09, 6'h0a};
    err_resp_set = 32'h0400_0000;
    foreach (ix[j]) begin
      rg = (ix[j] == 6'h09) ? csd_reg : cid_reg;
      send(CRSF_R2, ix[j], 1'b0);
      chk(cmd_skip, j == 0, "skip once");
      wait_frame();
      chk(h_n, 8'h88, "r2 length");
      chk(h_frame, {2'b00, 6'h3f, rg[127:1], 1'b1}, "r2");
    end
    chk(status_word, 32'h0400_0000, "kept past r2");
    $display("test r2 done");
  endtask

  task automatic t_r3();
    for (int p = 0; p < 2; p++) begin
      power_up_done = p[0];
      ocr_volt = p[0] ? 31'h00ff_8000 : 31'h7f00_0080;
      send(CRSF_R3, 6'h01, 1'b0);
      wait_frame();
      chk(h_n, 8'h30, "r3 length");
      chk(h_frame[47:0], {2'b00, 6'h3f, p[0], ocr_volt, 7'h7f, 1'b1},
          "r3");
    end
    $display("test r3 done");
  endtask

  task automatic t_r1b();
    int k;
    k = 0;
    send(CRSF_R1B, 6'h07, 1'b1);
    wait_frame();
    chk(h_frame[47:0], r1(6'h07, 32'h0400_0000), "r1b");
    chk(status_word, 32'h0, "r1b clears");
    chk(h_dat0, 1'b0, "busy low");
    chk(req_ready, 1'b0, "busy refuses");
    busy_done = 1'b1;
    while (dat0_oe && k < 5) begin
      step(1);
      k++;
    end
    busy_done = 1'b0;
    if (k >= 5) give_up("busy end");
    chk(h_dat0, 1'b1, "busy ends");
    chk(req_ready, 1'b1, "ready again");
    $display("test r1b done");
  endtask

  task automatic t_exec();
    addr_oor_exec = 1'b1;
    err_exec_set = 32'h0008_0000;
    step(1);
    {addr_oor_exec, err_exec_set} = '0;
    chk(exec_abort, 1'b1, "abort");
    chk(status_word, 32'h8008_0000, "exec set");
    step(1);
    chk(exec_abort, 1'b0, "abort pulse");
    misalign_resp = 1'b1;
    send(CRSF_R1, 6'h0d, 1'b0);
    wait_frame();
    chk(h_frame[47:0], r1(6'h0d, 32'hc008_0000), "next");
    chk(status_word, 32'h0, "read clears");
    misalign_exec = 1'b1;
    step(1);
    misalign_exec = 1'b0;
    chk(status_word, 32'h4000_0000, "late misalign");
    send(CRSF_R1, 6'h0c, 1'b0);
    wait_frame();
    chk(h_frame[47:0], r1(6'h0c, 32'h4000_0000), "stop");
    $display("test exec done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    {clk, rst_n, req_valid, busy_done, cmd_valid, power_up_done} = '0;
    {addr_oor_resp, addr_oor_exec, misalign_resp, misalign_exec} = '0;
    {stat_level, err_resp_set, err_exec_set, ocr_volt} = '0;
    req = '{rtype: CRSF_R1, index: 6'h00, busy: 1'b0};
    cid_reg = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3211;
    csd_reg = 128'h5a5a_c3c3_0f0f_9696_a5a5_3c3c_f0f0_6969;
    n_fail = 0;
    n_checks = 0;
    step(5);
    rst_n = 1'b1;
    chk({cmd_o, cmd_oe, dat0_o, dat0_oe, req_ready}, 5'h15, "reset");
    chk(status_word, 32'h0, "reset status");
    t_r1();
    t_r2();
    t_r3();
    t_r1b();
    t_exec();
    test_done();
  end
endmodule
